// ==== rtl/msiw_top.sv ====
// status, interrupt enable and warning logic of the metering device
// assumes register requests from the serial port engine on clk, detection
// events as same-clock levels and accumulator steps as same-clock pulses
`timescale 1ns/1ps
`default_nettype none
`include "msiw_regs.svh"

// Contract
// - interrupt line a high when any status a flag and its enable set
// - interrupt line b high when any status b flag and its enable set
// - status a at 01H, resets zero, read returns flags then clears
// - status b at 02H, resets zero, read returns flags then clears
// - first checksum fail sets status a bit 14 and warning output
// - second checksum fail sets status a bit 12 and warning output
// - third checksum fail sets status a bit 10 and warning output
// - fourth checksum fail sets status a bit 8 and warning output
// - voltage phase sequence fault sets status a bit 7
// - current phase sequence fault sets status a bit 6
// - voltage dip below threshold sets status a bit 3
// - voltage loss on any phase sets status a bit 2
// - sampled neutral over its limit sets status b bit 15
// - computed neutral over its limit sets status b bit 14
// - voltage distortion over limit sets status b bit 11
// - current distortion over limit sets status b bit 10
// - harmonic results ready sets status b bit 9
// - bits 7..4 reactive, 3..0 active reversals: sum, a, b, c
// - reversal judged from accumulator steps at 0.01 or 0.1 grain
// - enable a at 03H resets zero, bits 10,7,6,3,2 gate line a
// - enable b at 04H resets zero, bits 15,14,11,10,9,7..0 gate line b
module msiw_top (
    input wire logic clk,
    input wire logic rst,
    input wire msiw_pkg::msiw_req_t req,
    output logic [`MSIW_DATA_W-1:0] rdata,
    output logic rvalid,
    input wire msiw_pkg::msiw_events_t events,
    input wire msiw_pkg::msiw_energy_t energy,
    input wire logic accumulator_resolution_select,
    output logic interrupt_line_a,
    output logic interrupt_line_b,
    output logic warning_output
);

    // ****************************************
    // declarations
    // ****************************************
    logic sel_status_a;
    logic sel_status_b;
    logic sel_enable_a;
    logic sel_enable_b;
    logic read_status_a;
    logic read_status_b;
    logic [`MSIW_DATA_W-1:0] set_a;
    logic [`MSIW_DATA_W-1:0] set_b;
    logic [`MSIW_DATA_W-1:0] status_a;
    logic [`MSIW_DATA_W-1:0] status_b;
    logic [`MSIW_DATA_W-1:0] enable_a_reg;
    logic [`MSIW_DATA_W-1:0] enable_b_reg;
    logic [`MSIW_DATA_W-1:0] rdata_next;
    logic [`MSIW_REV_W-1:0] reversal;
    logic [`MSIW_DATA_W-1:0] pending_a;
    logic [`MSIW_DATA_W-1:0] pending_b;
    logic [`MSIW_DATA_W-1:0] warn_src;

    // ****************************************
    // address decode
    // ****************************************
    always_comb begin
        sel_status_a = 1'b0;
        sel_status_b = 1'b0;
        sel_enable_a = 1'b0;
        sel_enable_b = 1'b0;
        if (req.addr == `MSIW_OFF_STATUS_A) begin
            sel_status_a = 1'b1;
        end else if (req.addr == `MSIW_OFF_STATUS_B) begin
            sel_status_b = 1'b1;
        end else if (req.addr == `MSIW_OFF_ENABLE_A) begin
            sel_enable_a = 1'b1;
        end else if (req.addr == `MSIW_OFF_ENABLE_B) begin
            sel_enable_b = 1'b1;
        end
    end

    assign read_status_a = req.rd && sel_status_a;
    assign read_status_b = req.rd && sel_status_b;

    // ****************************************
    // status a sources
    // ****************************************
    always_comb begin
        set_a = `MSIW_RST_STATUS_A;
        set_a[`MSIW_BIT_CHECKSUM_FIRST] = events.checksum_first_fail;
        set_a[`MSIW_BIT_CHECKSUM_SECOND] = events.checksum_second_fail;
        set_a[`MSIW_BIT_CHECKSUM_THIRD] = events.checksum_third_fail;
        set_a[`MSIW_BIT_CHECKSUM_FOURTH] = events.checksum_fourth_fail;
        set_a[`MSIW_BIT_VOLTAGE_SEQ] = events.voltage_sequence_fault;
        set_a[`MSIW_BIT_CURRENT_SEQ] = events.current_sequence_fault;
        set_a[`MSIW_BIT_VOLTAGE_DIP] = events.voltage_dip_flag;
        set_a[`MSIW_BIT_VOLTAGE_LOSS] = events.voltage_loss_flag;
    end

    // ****************************************
    // status b sources
    // ****************************************
    always_comb begin
        set_b = `MSIW_RST_STATUS_B;
        set_b[`MSIW_BIT_SAMPLED_NEUTRAL] = events.sampled_neutral_over;
        set_b[`MSIW_BIT_COMPUTED_NEUTRAL] = events.computed_neutral_over;
        set_b[`MSIW_BIT_VOLTAGE_DIST] = events.voltage_distortion_over;
        set_b[`MSIW_BIT_CURRENT_DIST] = events.current_distortion_over;
        set_b[`MSIW_BIT_HARMONIC_READY] = events.harmonic_results_ready;
        set_b[`MSIW_REV_LSB +: `MSIW_REV_W] = reversal;
    end

    // ****************************************
    // direction detectors
    // ****************************************
    // accumulator based detection
    for (genvar i = 0; i < `MSIW_REV_W; i++) begin : g_dir
        msiw_dir_detect u_dir (
            .clk(clk),
            .rst(rst),
            .coarse(accumulator_resolution_select),
            .step(energy.step[i]),
            .negative(energy.negative[i]),
            .reversal(reversal[i])
        );
    end

    // ****************************************
    // status registers
    // ****************************************
    // status a flags
    msiw_status_reg #(
        .MASK(`MSIW_MASK_STATUS_A),
        .RST_VALUE(`MSIW_RST_STATUS_A)
    ) u_status_a (
        .clk(clk),
        .rst(rst),
        .set_bits(set_a),
        .clear(read_status_a),
        .flags(status_a)
    );

    msiw_status_reg #(
        .MASK(`MSIW_MASK_STATUS_B),
        .RST_VALUE(`MSIW_RST_STATUS_B)
    ) u_status_b (
        .clk(clk),
        .rst(rst),
        .set_bits(set_b),
        .clear(read_status_b),
        .flags(status_b)
    );

    // ****************************************
    // enable registers
    // ****************************************
    // enable a write
    always_ff @(posedge clk) begin
        if (rst) begin
            enable_a_reg <= `MSIW_RST_ENABLE_A;
        end else if (req.wr && sel_enable_a) begin
            enable_a_reg <= req.wdata & `MSIW_MASK_ENABLE_A;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            enable_b_reg <= `MSIW_RST_ENABLE_B;
        end else if (req.wr && sel_enable_b) begin
            enable_b_reg <= req.wdata & `MSIW_MASK_ENABLE_B;
        end
    end

    // ****************************************
    // read data
    // ****************************************
    // status reads capture the flags before the clear lands
    always_comb begin
        rdata_next = 16'h0000;
        if (sel_status_a) begin
            rdata_next = status_a;
        end else if (sel_status_b) begin
            rdata_next = status_b;
        end else if (sel_enable_a) begin
            rdata_next = enable_a_reg;
        end else if (sel_enable_b) begin
            rdata_next = enable_b_reg;
        end
    end

    // data held until the next read
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata <= 16'h0000;
        end else if (req.rd) begin
            rdata <= rdata_next;
        end
    end

    // answer strobe one cycle after the read
    always_ff @(posedge clk) begin
        if (rst) begin
            rvalid <= 1'b0;
        end else begin
            rvalid <= req.rd;
        end
    end

    // ****************************************
    // output pins
    // ****************************************
    // pending vectors kept apart so each pin has its own gate
    assign pending_a = status_a & enable_a_reg;
    assign pending_b = status_b & enable_b_reg;
    assign warn_src = status_a & `MSIW_MASK_WARN_A;

    // registered pins, one cycle behind the flags, glitch free off chip
    // line a gate
    always_ff @(posedge clk) begin
        if (rst) begin
            interrupt_line_a <= 1'b0;
        end else begin
            interrupt_line_a <= |pending_a;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            interrupt_line_b <= 1'b0;
        end else begin
            interrupt_line_b <= |pending_b;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            warning_output <= 1'b0;
        end else begin
            warning_output <= |warn_src;
        end
    end

endmodule // msiw_top

`default_nettype wire

// ==== rtl/msiw_regs.svh ====
// register offsets, field positions, reset values and counts of the metering status block
// assumes inclusion by bare name from the package and the design modules
`ifndef MSIW_REGS_SVH
`define MSIW_REGS_SVH

// ****************************************
// offsets
// ****************************************
`define MSIW_ADDR_W 10
`define MSIW_OFF_STATUS_A 10'h001
`define MSIW_OFF_STATUS_B 10'h002
`define MSIW_OFF_ENABLE_A 10'h003
`define MSIW_OFF_ENABLE_B 10'h004

// ****************************************
// reset values and implemented bits
// ****************************************
`define MSIW_DATA_W 16
`define MSIW_RST_STATUS_A 16'h0000
`define MSIW_RST_STATUS_B 16'h0000
`define MSIW_RST_ENABLE_A 16'h0000
`define MSIW_RST_ENABLE_B 16'h0000
`define MSIW_MASK_STATUS_A 16'h55CC
`define MSIW_MASK_STATUS_B 16'hCEFF
`define MSIW_MASK_ENABLE_A 16'h04CC
`define MSIW_MASK_ENABLE_B 16'hCEFF
`define MSIW_MASK_WARN_A 16'h5500

// ****************************************
// field positions, status a
// ****************************************
`define MSIW_BIT_CHECKSUM_FIRST 14
`define MSIW_BIT_CHECKSUM_SECOND 12
`define MSIW_BIT_CHECKSUM_THIRD 10
`define MSIW_BIT_CHECKSUM_FOURTH 8
`define MSIW_BIT_VOLTAGE_SEQ 7
`define MSIW_BIT_CURRENT_SEQ 6
`define MSIW_BIT_VOLTAGE_DIP 3
`define MSIW_BIT_VOLTAGE_LOSS 2

// ****************************************
// field positions, status b
// ****************************************
`define MSIW_BIT_SAMPLED_NEUTRAL 15
`define MSIW_BIT_COMPUTED_NEUTRAL 14
`define MSIW_BIT_VOLTAGE_DIST 11
`define MSIW_BIT_CURRENT_DIST 10
`define MSIW_BIT_HARMONIC_READY 9
`define MSIW_REV_LSB 0
`define MSIW_REV_W 8

// ****************************************
// direction resolution
// ****************************************
// accumulator steps arrive at the fine grain; the coarse grain is ten of them
`define MSIW_FINE_STEPS 4'h1
`define MSIW_COARSE_STEPS 4'hA

`endif

// ==== rtl/msiw_pkg.sv ====
// types shared by the metering status block
// assumes msiw_regs.svh is on the include path
`include "msiw_regs.svh"

package msiw_pkg;

    typedef logic [`MSIW_DATA_W-1:0] msiw_word_t;

    // register access from the serial port engine
    typedef struct packed {
        logic rd;
        logic wr;
        logic [`MSIW_ADDR_W-1:0] addr;
        msiw_word_t wdata;
    } msiw_req_t;

    // level events from the detection logic
    typedef struct packed {
        logic checksum_first_fail;
        logic checksum_second_fail;
        logic checksum_third_fail;
        logic checksum_fourth_fail;
        logic voltage_sequence_fault;
        logic current_sequence_fault;
        logic voltage_dip_flag;
        logic voltage_loss_flag;
        logic sampled_neutral_over;
        logic computed_neutral_over;
        logic voltage_distortion_over;
        logic current_distortion_over;
        logic harmonic_results_ready;
    } msiw_events_t;

    // accumulator steps, bit 7 reactive sum down to bit 0 active phase c
    typedef struct packed {
        logic [`MSIW_REV_W-1:0] step;
        logic [`MSIW_REV_W-1:0] negative;
    } msiw_energy_t;

    typedef enum logic [2:0] {
        MSIW_DIR_NONE = 3'b001,
        MSIW_DIR_FWD = 3'b010,
        MSIW_DIR_REV = 3'b100
    } msiw_dir_t;

endpackage

// ==== rtl/msiw_status_reg.sv ====
// one read-to-clear sticky status register
// assumes set and read strobes on the same clock as the register
`timescale 1ns/1ps
`default_nettype none
`include "msiw_regs.svh"

module msiw_status_reg #(
    parameter logic [`MSIW_DATA_W-1:0] MASK = `MSIW_MASK_STATUS_A,
    parameter logic [`MSIW_DATA_W-1:0] RST_VALUE = `MSIW_RST_STATUS_A
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [`MSIW_DATA_W-1:0] set_bits,
    input wire logic clear,
    output logic [`MSIW_DATA_W-1:0] flags
);

    logic [`MSIW_DATA_W-1:0] flags_reg;
    logic [`MSIW_DATA_W-1:0] flags_next;

    // ****************************************
    // sticky flags
    // ****************************************
    // set wins over clear so an event in the read cycle survives
    always_comb begin
        flags_next = clear ? RST_VALUE : flags_reg;
        flags_next = (flags_next | set_bits) & MASK;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            flags_reg <= RST_VALUE;
        end else begin
            flags_reg <= flags_next;
        end
    end

    assign flags = flags_reg;

endmodule // msiw_status_reg

`default_nettype wire

// ==== rtl/msiw_dir_detect.sv ====
// energy direction change detector for one accumulator
// assumes one step pulse per finest accumulator grain, same clock
`timescale 1ns/1ps
`default_nettype none
`include "msiw_regs.svh"

module msiw_dir_detect (
    input wire logic clk,
    input wire logic rst,
    input wire logic coarse,
    input wire logic step,
    input wire logic negative,
    output logic reversal
);

    msiw_pkg::msiw_dir_t dir_reg;
    logic [3:0] run_reg;
    logic run_neg_reg;
    logic [3:0] need;
    logic run_same;
    logic confirmed;

    assign need = coarse ? `MSIW_COARSE_STEPS : `MSIW_FINE_STEPS;
    assign run_same = (run_neg_reg == negative) && (run_reg != 4'h0);
    // direction counts only once a whole grain moved one way
    assign confirmed = step && ((run_same ? run_reg + 4'h1 : 4'h1) >= need);

    always_ff @(posedge clk) begin
        if (rst) begin
            run_reg <= 4'h0;
            run_neg_reg <= 1'b0;
        end else if (confirmed) begin
            run_reg <= 4'h0;
        end else if (step) begin
            run_reg <= run_same ? run_reg + 4'h1 : 4'h1;
            run_neg_reg <= negative;
        end
    end

    // ****************************************
    // direction state
    // ****************************************
    // first confirmed grain only sets direction, no flag
    always_ff @(posedge clk) begin
        if (rst) begin
            dir_reg <= msiw_pkg::MSIW_DIR_NONE;
            reversal <= 1'b0;
        end else begin
            reversal <= 1'b0;
            if (confirmed) begin
                case (dir_reg)
                    msiw_pkg::MSIW_DIR_FWD: begin
                        reversal <= negative;
                    end
                    msiw_pkg::MSIW_DIR_REV: begin
                        reversal <= !negative;
                    end
                    default: begin
                        reversal <= 1'b0;
                    end
                endcase
                dir_reg <= negative ? msiw_pkg::MSIW_DIR_REV : msiw_pkg::MSIW_DIR_FWD;
            end
        end
    end

endmodule // msiw_dir_detect

`default_nettype wire

// ==== testbench/msiw_monitor.sv ====
// checker for the metering status block, watching the top ports only
// assumes one clock domain and a synchronous active high reset
`timescale 1ns/1ps
`default_nettype none
`include "msiw_regs.svh"

module msiw_monitor (
    input wire logic clk,
    input wire logic rst,
    input wire msiw_pkg::msiw_req_t req,
    input wire logic [`MSIW_DATA_W-1:0] rdata,
    input wire logic rvalid,
    input wire msiw_pkg::msiw_events_t events,
    input wire msiw_pkg::msiw_energy_t energy,
    input wire logic accumulator_resolution_select,
    input wire logic interrupt_line_a,
    input wire logic interrupt_line_b,
    input wire logic warning_output
);
    // ****************************************
    // register port and pins
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_rd_ans;
        req.rd |=> rvalid;
    endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("no answer after read");
    property p_ans_cause;
        rvalid |-> $past(req.rd);
    endproperty
    a_ans_cause: assert property (p_ans_cause) else $error("answer without read");
    property p_unmapped;
        req.rd && (req.addr == 10'h000 || req.addr > 10'h004) |=> rdata == 16'h0000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_warn_first;
        events.checksum_first_fail |-> ##2 warning_output;
    endproperty
    a_warn_first: assert property (p_warn_first) else $error("warning missed");
    property p_warn_second;
        events.checksum_second_fail |-> ##2 warning_output;
    endproperty
    a_warn_second: assert property (p_warn_second) else $error("warning missed");
    property p_warn_third;
        events.checksum_third_fail |-> ##2 warning_output;
    endproperty
    a_warn_third: assert property (p_warn_third) else $error("warning missed");
    property p_warn_fourth;
        events.checksum_fourth_fail |-> ##2 warning_output;
    endproperty
    a_warn_fourth: assert property (p_warn_fourth) else $error("warning missed");
    // read clears, so the pins drop two cycles later
    property p_warn_clear;
        req.rd && req.addr == 10'h001 && events[12:9] == 4'h0 |-> ##2 !warning_output;
    endproperty
    a_warn_clear: assert property (p_warn_clear) else $error("warning stuck");
    property p_line_a_clear;
        req.rd && req.addr == 10'h001 && events[12:5] == 8'h00 |-> ##2 !interrupt_line_a;
    endproperty
    a_line_a_clear: assert property (p_line_a_clear) else $error("line a stuck");
    // a step one cycle before the read still lands after the clear
    property p_line_b_clear;
        req.rd && req.addr == 10'h002 && events[4:0] == 5'h00 && energy.step == 8'h00
            && $past(energy.step) == 8'h00 |-> ##2 !interrupt_line_b;
    endproperty
    a_line_b_clear: assert property (p_line_b_clear) else $error("line b stuck");
endmodule // msiw_monitor

bind msiw_top msiw_monitor i_msiw_monitor (.clk(clk), .rst(rst), .req(req), .rdata(rdata),
    .rvalid(rvalid), .events(events), .energy(energy),
    .accumulator_resolution_select(accumulator_resolution_select),
    .interrupt_line_a(interrupt_line_a), .interrupt_line_b(interrupt_line_b),
    .warning_output(warning_output));
`default_nettype wire

// ==== testbench/msiw_host.sv ====
// host model: register reads and writes, interrupt servicing
// assumes the block answers one cycle after a read strobe
`timescale 1ns/1ps
`default_nettype none
`include "msiw_regs.svh"

module msiw_host (
    input wire logic clk,
    output var msiw_pkg::msiw_req_t req,
    input wire logic [`MSIW_DATA_W-1:0] rdata,
    input wire logic rvalid,
    input wire logic interrupt_line_a,
    input wire logic interrupt_line_b
);
    // ****************************************
    // bus cycles
    // ****************************************
    initial req = '0;

    // released bus shows the inverse, not a stale value
    task automatic rd(input logic [9:0] a, output logic [15:0] d, output logic v);
        @(posedge clk);
        req <= msiw_pkg::msiw_req_t'({2'b10, a, 16'h0000});
        @(posedge clk);
        req <= msiw_pkg::msiw_req_t'({2'b00, ~a, 16'hFFFF});
        #1;
        d = rdata;
        v = rvalid;
    endtask

    task automatic wr(input logic [9:0] a, input logic [15:0] w);
        @(posedge clk);
        req <= msiw_pkg::msiw_req_t'({2'b01, a, w});
        @(posedge clk);
        req <= msiw_pkg::msiw_req_t'({2'b00, ~a, ~w});
    endtask

    task automatic service(output logic [15:0] sa, output logic [15:0] sb);
        logic v;
        sa = 16'h0000;
        sb = 16'h0000;
        if (interrupt_line_a === 1'b1) rd(`MSIW_OFF_STATUS_A, sa, v);
        if (interrupt_line_b === 1'b1) rd(`MSIW_OFF_STATUS_B, sb, v);
    endtask
endmodule // msiw_host
`default_nettype wire

// ==== testbench/tb_top.sv ====
// self-checking bench for the metering status block
// assumes msiw_regs.svh on the include path, host model and checker compiled
`timescale 1ns/1ps
`default_nettype none
`include "msiw_regs.svh"

module tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    msiw_pkg::msiw_req_t req;
    msiw_pkg::msiw_events_t events = '0;
    msiw_pkg::msiw_energy_t energy = '0;
    logic res_sel = 1'b0;
    logic [15:0] rdata, ena, enb, d, sa, sb;
    logic rvalid, line_a, line_b, warn, v, ea, eb;
    int num_errors = 0;
    int num_checks = 0;
    logic [31:0] seed = 32'h0000_75B1;
    int sbit[13] = '{14, 12, 10, 8, 7, 6, 3, 2, 15, 14, 11, 10, 9};

    always #2.5 clk = ~clk;

    msiw_top i_msiw_top (.clk(clk), .rst(rst), .req(req), .rdata(rdata), .rvalid(rvalid),
        .events(events), .energy(energy), .accumulator_resolution_select(res_sel),
        .interrupt_line_a(line_a), .interrupt_line_b(line_b), .warning_output(warn));
    msiw_host i_msiw_host (.clk(clk), .req(req), .rdata(rdata), .rvalid(rvalid),
        .interrupt_line_a(line_a), .interrupt_line_b(line_b));

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    // reserved enable bits never gate a pin
    function automatic logic en_hit(input int i, input logic [15:0] en);
        logic [15:0] m;
        m = (i < 8) ? `MSIW_MASK_ENABLE_A : `MSIW_MASK_ENABLE_B;
        return m[sbit[i]] & en[sbit[i]];
    endfunction

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic rchk(input logic [9:0] a, input logic [15:0] exp);
        i_msiw_host.rd(a, d, v);
        chk(16'(v), 16'h0001);
        chk(d, exp);
    endtask

    task automatic pins(input logic a, input logic b, input logic w);
        chk(16'(line_a), 16'(a));
        chk(16'(line_b), 16'(b));
        chk(16'(warn), 16'(w));
    endtask

    task automatic steps(input logic [7:0] m, input logic neg, input int n);
        repeat (n) begin
            @(posedge clk);
            energy <= msiw_pkg::msiw_energy_t'({m, neg ? m : 8'h00});
            @(posedge clk);
            energy <= '0;
        end
        cyc(3);
    endtask

    task automatic report_and_stop;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // ****************************************
    // tests
    // ****************************************
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        report_and_stop;
    end

    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        i_msiw_host.wr(10'h005, 16'hFFFF);
        for (int a = 0; a < 6; a++) rchk(10'(a), 16'h0000);
        $display("test reset done");
        for (int p = 0; p < 2; p++) begin
            seed = xs(seed);
            ena = p ? ~ena : seed[15:0];
            enb = p ? ~enb : seed[31:16];
            i_msiw_host.wr(`MSIW_OFF_ENABLE_A, ena);
            i_msiw_host.wr(`MSIW_OFF_ENABLE_B, enb);
            i_msiw_host.wr(`MSIW_OFF_STATUS_A, 16'hFFFF);
            rchk(`MSIW_OFF_ENABLE_A, ena & `MSIW_MASK_ENABLE_A);
            rchk(`MSIW_OFF_ENABLE_B, enb & `MSIW_MASK_ENABLE_B);
            rchk(`MSIW_OFF_STATUS_A, 16'h0000);
            for (int i = 0; i < 13; i++) begin
                ea = (i < 8) && en_hit(i, ena);
                eb = (i >= 8) && en_hit(i, enb);
                @(posedge clk);
                events <= msiw_pkg::msiw_events_t'(13'h1000 >> i);
                @(posedge clk);
                events <= '0;
                cyc(2);
                pins(ea, eb, i < 4);
                i_msiw_host.service(sa, sb);
                chk(sa | sb, (ea | eb) ? 16'h0001 << sbit[i] : 16'h0000);
                rchk(i < 8 ? 10'h001 : 10'h002, (ea | eb) ? 16'h0000 : 16'h0001 << sbit[i]);
                cyc(2);
                pins(1'b0, 1'b0, 1'b0);
            end
        end
        $display("test events done");
        for (int j = 0; j < 8; j++) begin
            steps(8'h01 << j, 1'b0, 1);
            steps(8'h01 << j, 1'b1, 1);
            pins(1'b0, enb[j], 1'b0);
            rchk(`MSIW_OFF_STATUS_B, 16'h0001 << j);
        end
        @(posedge clk);
        res_sel <= 1'b1;
        steps(8'hFF, 1'b1, 10);
        steps(8'hFF, 1'b0, 9);
        rchk(`MSIW_OFF_STATUS_B, 16'h0000);
        steps(8'hFF, 1'b0, 1);
        rchk(`MSIW_OFF_STATUS_B, 16'h00FF);
        $display("test direction done");
        // set wins: a level still high in the read cycle survives the clear
        @(posedge clk);
        events <= msiw_pkg::msiw_events_t'(13'h0001);
        rchk(`MSIW_OFF_STATUS_B, 16'h0200);
        @(posedge clk);
        events <= '0;
        rchk(`MSIW_OFF_STATUS_B, 16'h0200);
        rchk(`MSIW_OFF_STATUS_B, 16'h0000);
        // reset in mid-run drops flags, enables and pins together
        i_msiw_host.wr(`MSIW_OFF_ENABLE_A, 16'hFFFF);
        @(posedge clk);
        events <= msiw_pkg::msiw_events_t'(13'h1FFF);
        @(posedge clk);
        events <= '0;
        cyc(1);
        pins(1'b1, |(enb & 16'hCE00), 1'b1);
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        cyc(1);
        pins(1'b0, 1'b0, 1'b0);
        for (int a = 1; a < 5; a++) rchk(10'(a), 16'h0000);
        $display("test corner done");
        report_and_stop;
    end
endmodule // tb_top
`default_nettype wire
